// ---- phy_cfg_pkg.sv ----
// Constants and types for the PHY configuration and control register group
// Function
// - With the extension bit 11 set and a partner forced to 100 Mb/s, the link runs full duplex.
// - Bit 9 turns on robust crossover resolution.
// - Bit 8 turns on quick crossover resolution for forced 100 Mb/s on both ends.
// - Bit 7 makes the shared pad an interrupt output when set and a power-down input when clear.
// - Bit 6 forces the interrupt pin active while it is set.
// - Bits 5:3 ignore writes and read as zero.
// - Bit 1 is read-only, reads one once the cable test has completed, and resets to one.
// - Bit 2 is read-only, reads one when the cable test failed, and resets to zero.
// - Control bit 15 does a full reset including registers and then clears itself.
// - Control bit 14 restarts operation, keeps registers, and then clears itself.
// - Test lane bit 7 drives the test mode on all four channels.
// - With bit 7 clear, bits 6:5 pick channel A, B, C or D.
`default_nettype none
package phy_cfg_pkg;

  // ****************************************
  // Register map, word indexes and widths
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam logic [5:0] IDX_PHY_CONFIG_THREE = 6'h1e;
  localparam logic [5:0] IDX_SRST = 6'h1f;
  localparam logic [5:0] IDX_TMCH = 6'h25;
  localparam int LANES = 4;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int PHY_CONFIG_THREE_FDX = 11;
  localparam int PHY_CONFIG_THREE_ROBUST = 9;
  localparam int PHY_CONFIG_THREE_QUICK = 8;
  localparam int PHY_CONFIG_THREE_INTOE = 7;
  localparam int PHY_CONFIG_THREE_FORCE = 6;
  localparam int PHY_CONFIG_THREE_FAIL = 2;
  localparam int PHY_CONFIG_THREE_DONE = 1;
  localparam int PHY_CONFIG_THREE_KICK = 0;
  localparam int SRST_FULL = 15;
  localparam int SRST_REINIT = 14;
  localparam int TM_ALL = 7;
  localparam int TM_SEL_LO = 5;
  localparam int TM_RSVD_LO = 8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic DONE_RST = 1'b1;
  localparam logic FAIL_RST = 1'b0;
  localparam logic [7:0] TM_RSVD_VAL = 8'h04;
  localparam logic [2:0] TM_RST = 3'h0;

  // Writable configuration fields
  typedef struct packed {
    logic fdxExt;
    logic robust;
    logic quick;
    logic intOe;
    logic forceIrq;
    logic kick;
  } cfg_t;
  localparam cfg_t CFG_RST = '0;

  // Cable test sequencer
  typedef enum logic [1:0] {
    T_IDLE = 2'b01,
    T_RUN = 2'b10
  } test_state_t;

endpackage
`default_nettype wire

// ---- phy_config_control_regs.sv ----
// Configuration and control register group with its control outputs
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module phy_config_control_regs
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [phy_cfg_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [phy_cfg_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [phy_cfg_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  // Duplex and crossover
  input wire logic partnerForced100,
  input wire logic stdFullDuplex,
  output logic linkFullDuplex,
  output logic robustCrossoverEn,
  output logic quickCrossoverEn,
  // Shared interrupt or power-down pad
  input wire logic irqEvent,
  input wire logic irqPadIn,
  output logic irqPadOutN,
  output logic irqPadOe,
  output logic powerDownReq,
  // Cable test engine
  input wire logic cableTestEnd,
  input wire logic cableTestBad,
  output logic cableTestStart,
  // Device resets
  output logic fullResetPulse,
  output logic reinitPulse,
  // Test pattern lanes A..D
  output logic [phy_cfg_pkg::LANES-1:0] testLaneEn
);

  // ****************************************
  // Registers
  // ****************************************
  phy_cfg_pkg::cfg_t cfg_r;
  phy_cfg_pkg::test_state_t testState_r;
  logic done_r;
  logic fail_r;
  logic [2:0] tmSel_r;
  logic softFull_r;
  logic softReinit_r;
  logic waitReq_r;
  logic [phy_cfg_pkg::DATA_W-1:0] rdData_r;
  logic padSync1_r;
  logic padSync2_r;
  logic fdx_r;
  logic robust_r;
  logic quick_r;
  logic irqN_r;
  logic oe_r;
  logic pwdn_r;
  logic start_r;
  logic [phy_cfg_pkg::LANES-1:0] lanes_r;

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************
  wire logic [5:0] wordIdx = address[phy_cfg_pkg::ADDR_W-1:2];
  wire logic hitCfg3 = (wordIdx == phy_cfg_pkg::IDX_PHY_CONFIG_THREE);
  wire logic hitSrst = (wordIdx == phy_cfg_pkg::IDX_SRST);
  wire logic hitTmch = (wordIdx == phy_cfg_pkg::IDX_TMCH);
  wire logic doWrite = write && !waitReq_r;
  wire logic [15:0] cfgOld = {4'h0, cfg_r.fdxExt, 1'b0, cfg_r.robust, cfg_r.quick, cfg_r.intOe, cfg_r.forceIrq,
    3'h0, fail_r, done_r, cfg_r.kick};
  wire logic [15:0] cfgNew = merge16(cfgOld, writedata, byteenable);
  wire logic [15:0] srstNew = merge16({softFull_r, softReinit_r, 14'h0}, writedata, byteenable);
  wire logic [15:0] tmNew = merge16({phy_cfg_pkg::TM_RSVD_VAL, tmSel_r, 5'h00}, writedata, byteenable);
  wire logic wrCfg = doWrite && hitCfg3;
  wire logic wrSrst = doWrite && hitSrst;
  wire logic wrTm = doWrite && hitTmch;
  wire logic kickNow = wrCfg && cfgNew[phy_cfg_pkg::PHY_CONFIG_THREE_KICK];
  wire logic regRst = reset || softFull_r;

  // Read mux, unmapped words read zero
  wire logic [15:0] rdWord = hitCfg3 ? cfgOld :
    hitSrst ? {softFull_r, softReinit_r, 14'h0} :
    hitTmch ? {phy_cfg_pkg::TM_RSVD_VAL, tmSel_r, 5'h00} : 16'h0000;

  // ****************************************
  // Avalon answer, one wait cycle per access
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      waitReq_r <= 1'b1;
      rdData_r <= '0;
    end
    else if (ce)
    begin
      waitReq_r <= !((read || write) && waitReq_r);
      if (read && waitReq_r)
        rdData_r <= {16'h0000, rdWord};
    end
  end

  // ****************************************
  // Configuration fields
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (regRst)
    begin
      cfg_r <= phy_cfg_pkg::CFG_RST;
      tmSel_r <= phy_cfg_pkg::TM_RST;
    end
    else if (ce)
    begin
      if (wrCfg)
        cfg_r <= '{fdxExt: cfgNew[phy_cfg_pkg::PHY_CONFIG_THREE_FDX], robust: cfgNew[phy_cfg_pkg::PHY_CONFIG_THREE_ROBUST],
          quick: cfgNew[phy_cfg_pkg::PHY_CONFIG_THREE_QUICK], intOe: cfgNew[phy_cfg_pkg::PHY_CONFIG_THREE_INTOE],
          forceIrq: cfgNew[phy_cfg_pkg::PHY_CONFIG_THREE_FORCE], kick: cfgNew[phy_cfg_pkg::PHY_CONFIG_THREE_KICK]};
      if (wrTm)
        tmSel_r <= tmNew[phy_cfg_pkg::TM_ALL:phy_cfg_pkg::TM_SEL_LO];
    end
  end

  // ****************************************
  // Self-clearing soft resets
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (regRst)
    begin
      softFull_r <= 1'b0;
      softReinit_r <= 1'b0;
    end
    else if (ce)
    begin
      softFull_r <= wrSrst && srstNew[phy_cfg_pkg::SRST_FULL];
      softReinit_r <= wrSrst && srstNew[phy_cfg_pkg::SRST_REINIT];
    end
  end

  // ****************************************
  // Cable test sequencer
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (regRst)
    begin
      testState_r <= phy_cfg_pkg::T_IDLE;
      done_r <= phy_cfg_pkg::DONE_RST;
      fail_r <= phy_cfg_pkg::FAIL_RST;
      start_r <= 1'b0;
    end
    else if (ce)
    begin
      start_r <= 1'b0;
      unique case (testState_r)
        phy_cfg_pkg::T_IDLE:
        begin
          if (kickNow)
          begin
            testState_r <= phy_cfg_pkg::T_RUN;
            start_r <= 1'b1;
            done_r <= 1'b0;
            fail_r <= 1'b0;
          end
        end
        phy_cfg_pkg::T_RUN:
        begin
          if (cableTestEnd)
          begin
            testState_r <= phy_cfg_pkg::T_IDLE;
            done_r <= 1'b1;
            fail_r <= cableTestBad;
          end
        end
        default:
          testState_r <= phy_cfg_pkg::T_IDLE;
      endcase
    end
  end

  // ****************************************
  // Pad synchroniser
  // ****************************************
  // Two flops ahead of any logic, idle level high so reset makes no false edge
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      padSync1_r <= 1'b1;
      padSync2_r <= 1'b1;
    end
    else if (ce)
    begin
      padSync1_r <= irqPadIn;
      padSync2_r <= padSync1_r;
    end
  end

  // ****************************************
  // Control outputs
  // ****************************************
  // Next values, each registered once below
  wire logic fdx_nxt = (cfg_r.fdxExt && partnerForced100) || stdFullDuplex;
  wire logic irqN_nxt = !(cfg_r.forceIrq || irqEvent);
  wire logic pwdn_nxt = !cfg_r.intOe && !padSync2_r;
  wire logic [phy_cfg_pkg::LANES-1:0] lanes_nxt = tmSel_r[2] ? {phy_cfg_pkg::LANES{1'b1}} :
    phy_cfg_pkg::LANES'(1) << tmSel_r[1:0];

  // Output flops follow their next values one cycle late
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      fdx_r <= 1'b0;
      robust_r <= 1'b0;
      quick_r <= 1'b0;
      irqN_r <= 1'b1;
      oe_r <= 1'b0;
      pwdn_r <= 1'b0;
      lanes_r <= '0;
    end
    else if (ce)
    begin
      fdx_r <= fdx_nxt;
      robust_r <= cfg_r.robust;
      quick_r <= cfg_r.quick;
      oe_r <= cfg_r.intOe;
      irqN_r <= irqN_nxt;
      pwdn_r <= pwdn_nxt;
      lanes_r <= lanes_nxt;
    end
  end

  assign readdata = rdData_r;
  assign waitrequest = waitReq_r;
  assign linkFullDuplex = fdx_r;
  assign robustCrossoverEn = robust_r;
  assign quickCrossoverEn = quick_r;
  assign irqPadOutN = irqN_r;
  assign irqPadOe = oe_r;
  assign powerDownReq = pwdn_r;
  assign cableTestStart = start_r;
  assign fullResetPulse = softFull_r;
  assign reinitPulse = softReinit_r;
  assign testLaneEn = lanes_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  full_duplex_a: assert property (ce && cfg_r.fdxExt && partnerForced100 |=> linkFullDuplex)
    else $error("extended duplex not applied");
  robust_en_a: assert property (ce && wrCfg ##1 ce |=> robustCrossoverEn == $past(cfgNew[9], 2))
    else $error("robust crossover enable wrong");
  quick_en_a: assert property (ce && wrCfg ##1 ce |=> quickCrossoverEn == $past(cfgNew[8], 2))
    else $error("quick crossover enable wrong");
  pad_mode_a: assert property (ce && cfg_r.intOe |=> irqPadOe && !powerDownReq)
    else $error("pad mode wrong");
  force_irq_a: assert property (ce && cfg_r.forceIrq |=> !irqPadOutN)
    else $error("forced interrupt not driven");
  reserved_zero_a: assert property (hitCfg3 && read && waitReq_r && ce |=> readdata[5:3] == 3'h0)
    else $error("reserved bits not zero");
  test_start_a: assert property (ce && kickNow && testState_r == phy_cfg_pkg::T_IDLE
    |=> cableTestStart && !done_r && !fail_r)
    else $error("cable test did not start");
  test_done_a: assert property (ce && testState_r == phy_cfg_pkg::T_RUN && cableTestEnd
    |=> done_r && fail_r == $past(cableTestBad))
    else $error("cable test end not recorded");
  full_reset_a: assert property (ce && wrSrst && srstNew[15] |=> fullResetPulse ##1 !fullResetPulse
    && cfg_r == phy_cfg_pkg::CFG_RST && done_r)
    else $error("soft full reset wrong");
  reinit_a: assert property (ce && wrSrst && srstNew[14] && !srstNew[15] |=> reinitPulse ##1 !reinitPulse
    && $stable(cfg_r))
    else $error("soft restart wrong");
  lanes_all_a: assert property (ce && tmSel_r[2] |=> testLaneEn == 4'hf)
    else $error("all lanes not driven");
  lane_one_a: assert property (ce && !tmSel_r[2] |=> $onehot(testLaneEn))
    else $error("single lane select wrong");
  answer_time_a: assert property ((read || write) && waitReq_r && ce |=> !waitrequest)
    else $error("bus answer late");
  wait_idle_a: assert property (ce && !read && !write |=> waitrequest)
    else $error("bus answer without request");
  start_once_a: assert property (cableTestStart && ce |=> !cableTestStart)
    else $error("cable test start longer than one cycle");
  status_ro_a: assert property (ce && wrCfg && !kickNow && testState_r == phy_cfg_pkg::T_IDLE
    |=> $stable(done_r) && $stable(fail_r))
    else $error("status bits changed by a write");

  test_run_c: cover property (kickNow ##[1:20] cableTestEnd);
  test_fail_c: cover property (testState_r == phy_cfg_pkg::T_RUN && cableTestEnd && cableTestBad);
  full_reset_c: cover property (fullResetPulse);
  power_down_c: cover property (powerDownReq);
  reinit_c: cover property (reinitPulse);

endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking testbench for the configuration and control register group
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ****************************************
  // Signals and addresses
  // ****************************************
  localparam logic [7:0] A_CFG = {phy_cfg_pkg::IDX_PHY_CONFIG_THREE, 2'b00};
  localparam logic [7:0] A_CTL = {phy_cfg_pkg::IDX_SRST, 2'b00};
  localparam logic [7:0] A_TM = {phy_cfg_pkg::IDX_TMCH, 2'b00};
  logic clk = 1'b0, reset = 1'b1, ce = 1'b1, read = 1'b0, write = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h0, readdata;
  logic [3:0] byteenable = 4'h3;
  logic waitrequest, partnerForced100 = 1'b0, stdFullDuplex = 1'b0, irqEvent = 1'b0, irqPadIn = 1'b1;
  logic cableTestEnd = 1'b0, cableTestBad = 1'b0, linkFullDuplex, robustCrossoverEn, quickCrossoverEn;
  logic irqPadOutN, irqPadOe, powerDownReq, cableTestStart, fullResetPulse, reinitPulse;
  logic [3:0] testLaneEn;
  int fails = 0, check_count = 0, starts = 0, fulls = 0, reinits = 0;

  phy_config_control_regs i_phy_config_control_regs (.clk, .reset, .ce, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .partnerForced100, .stdFullDuplex, .linkFullDuplex, .robustCrossoverEn,
    .quickCrossoverEn, .irqEvent, .irqPadIn, .irqPadOutN, .irqPadOe, .powerDownReq, .cableTestEnd, .cableTestBad,
    .cableTestStart, .fullResetPulse, .reinitPulse, .testLaneEn);

  // Clock generator, 25 ns period
  initial
  begin
    forever #12.5 clk = ~clk;
  end

  // Pulse counters for start and reset strobes
  always @(posedge clk)
  begin
    if (cableTestStart === 1'b1) starts++;
    if (fullResetPulse === 1'b1) fulls++;
    if (reinitPulse === 1'b1) reinits++;
  end

  // ****************************************
  // Helper tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // One bus cycle, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    @(posedge clk);
    address <= a;
    writedata <= {16'hffff, d};
    byteenable <= be;
    write <= wr;
    read <= !wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'h3, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string msg);
    logic [31:0] q;
    bus(1'b0, a, 16'h0, 4'h3, q);
    chk(q, {16'h0000, e}, msg);
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Pulse the end-of-test strobe for one cycle
  task automatic finish_test(input logic bad);
    @(posedge clk);
    cableTestEnd <= 1'b1;
    cableTestBad <= bad;
    @(posedge clk);
    cableTestEnd <= 1'b0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd(A_CFG, 16'h0002, "cfg reset");
    rd(A_CTL, 16'h0000, "ctl reset");
    rd(A_TM, 16'h0400, "lane reset");
    chk({irqPadOutN, irqPadOe, testLaneEn}, 6'h21, "outputs at reset");
    rd(8'h00, 16'h0000, "unmapped read");
    $display("test reset done");
  endtask

  task automatic t_cfg();
    logic [31:0] q;
    bus(1'b1, A_CFG, 16'hffff, 4'h2, q);
    rd(A_CFG, 16'h0b02, "upper lane only");
    partnerForced100 <= 1'b1;
    settle(3);
    chk({linkFullDuplex, robustCrossoverEn, quickCrossoverEn}, 3'h7, "fdx and crossover");
    wr(A_CFG, 16'h00f8);
    rd(A_CFG, 16'h00c2, "pad bits");
    irqPadIn <= 1'b0;
    settle(5);
    chk({linkFullDuplex, quickCrossoverEn, irqPadOutN, irqPadOe, powerDownReq}, 5'h02, "forced irq");
    @(posedge clk);
    stdFullDuplex <= 1'b1;
    wr(A_CFG, 16'h0000);
    settle(5);
    chk({linkFullDuplex, irqPadOutN, irqPadOe, powerDownReq}, 4'hd, "power down input");
    @(posedge clk);
    irqEvent <= 1'b1;
    irqPadIn <= 1'b1;
    settle(5);
    chk({irqPadOutN, powerDownReq}, 2'h0, "normal irq");
    @(posedge clk);
    irqEvent <= 1'b0;
    $display("test cfg done");
  endtask

  task automatic t_cable();
    int s0 = starts;
    wr(A_CFG, 16'h0001);
    rd(A_CFG, 16'h0001, "done cleared at start");
    wr(A_CFG, 16'h0007);
    chk(starts - s0, 1, "kick refused while running");
    finish_test(1'b1);
    rd(A_CFG, 16'h0007, "failed test");
    wr(A_CFG, 16'h0001);
    rd(A_CFG, 16'h0001, "fail cleared at start");
    finish_test(1'b0);
    finish_test(1'b1);
    rd(A_CFG, 16'h0003, "good test, idle end ignored");
    chk(starts - s0, 2, "start pulses");
    $display("test cable done");
  endtask

  task automatic t_lanes();
    logic [3:0] exp [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hf};
    for (int i = 0; i < 5; i++)
    begin
      wr(A_TM, {8'hff, 3'(i + (i / 4) * 3), 5'h1f});
      settle(2);
      chk(testLaneEn, exp[i], "lane select");
      rd(A_TM, {8'h04, 3'(i + (i / 4) * 3), 5'h00}, "lane readback");
    end
    chk(testLaneEn, 4'hf, "all lanes");
    $display("test lanes done");
  endtask

  task automatic t_soft();
    int f0 = fulls, r0 = reinits;
    wr(A_CFG, 16'h0b40);
    wr(A_CTL, 16'h4000);
    rd(A_CTL, 16'h0000, "restart bit cleared");
    rd(A_CFG, 16'h0b42, "regs kept");
    chk(fulls - f0, 0, "no full reset on restart");
    chk(reinits - r0, 1, "restart pulse");
    wr(A_CTL, 16'hc000);
    wr(8'h00, 16'hffff);
    rd(8'h00, 16'h0000, "unmapped write ignored");
    rd(A_CTL, 16'h0000, "reset bit cleared");
    rd(A_CFG, 16'h0002, "cfg defaults");
    rd(A_TM, 16'h0400, "lane defaults");
    chk(fulls - f0, 1, "full reset pulse");
    $display("test soft done");
  endtask

  // Clock enable low freezes the outputs, high lets them follow again
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    irqEvent <= 1'b1;
    settle(3);
    chk(irqPadOutN, 1'b1, "held while ce low");
    @(posedge clk);
    ce <= 1'b1;
    settle(2);
    chk(irqPadOutN, 1'b0, "event seen with ce high");
    @(posedge clk);
    irqEvent <= 1'b0;
    $display("test freeze done");
  endtask

  // ****************************************
  // Verdict and main sequence
  // ****************************************
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    #(25 * 20000);
    fails++;
    summarize();
  end

  // Reset for five cycles, then the scenarios
  initial
  begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_cfg();
    t_cable();
    t_lanes();
    t_soft();
    t_freeze();
    summarize();
  end
endmodule
`default_nettype wire
